// ### hdl/rst_seq_cfg.svh
// Constants for the reset source sequencer.
`ifndef RST_SEQ_CFG_SVH
`define RST_SEQ_CFG_SVH

`define CLK_PERIOD_NS 10
`define POWER_UP_TIMER_TIME_MS 64
`define POWER_UP_TIMER_CYCLES ((`POWER_UP_TIMER_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define POWER_UP_TIMER_CNT_W 23
`define BOR_FILTER_NS 1000
`define BOR_FILTER_CYCLES ((`BOR_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MASTER_CLEAR_PIN_FILTER_NS 200
`define MASTER_CLEAR_PIN_FILTER_CYCLES ((`MASTER_CLEAR_PIN_FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_CNT_W 8
`define ADDR_W 4
`define DATA_W 8
`define BROWNOUT_CONTROL_ADDR 4'h0
`define BROWNOUT_CONTROL_SW_EN_BIT 7
`define BROWNOUT_CONTROL_FAST_BIT 6
`define BROWNOUT_CONTROL_RDY_BIT 0
`define BROWNOUT_CONTROL_SW_EN_RESET 1'h1
`define BROWNOUT_CONTROL_FAST_RESET 1'h0
`define MODE_ALWAYS 2'h3
`define MODE_AWAKE 2'h2
`define MODE_SOFTWARE 2'h1
`define MODE_OFF 2'h0
`define SYNC_W 5
`define SYNC_RESET 5'h11

`endif

// ### hdl/rst_seq_pkg.sv
// Types shared by the reset source sequencer.
`default_nettype none
package rst_seq_pkg;

    typedef enum logic [1:0] {
        ST_POWER_HOLD,
        ST_TIMER,
        ST_WAIT,
        ST_RUN
    } seq_state_t;

    typedef struct packed {
        logic power_up_timer_enable_n;
        logic [1:0] brownout_mode_select;
        logic brownout_level_select;
        logic low_power_brownout_enable_n;
        logic master_clear_pin_enable;
        logic low_voltage_program_enable;
    } config_bits_t;

    typedef struct packed {
        logic watchdog_timer;
        logic reset_instruction;
        logic stack_overflow;
        logic stack_underflow;
        logic program_mode_exit;
    } reset_events_t;

endpackage
`default_nettype wire

// ### hdl/reset_source_sequencer.sv
// Reset source combiner, brown-out control and start-up sequencer.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`include "rst_seq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module reset_source_sequencer #(
    parameter logic [`POWER_UP_TIMER_CNT_W-1:0] POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_CNT_W'(`POWER_UP_TIMER_CYCLES)
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic por_vdd_low_in,
    input wire logic bor_vdd_below_in,
    input wire logic low_power_brownout_vdd_low_in,
    input wire logic brownout_circuit_ready_in,
    input wire logic master_clear_pin_n_in,
    input wire logic osc_startup_done_in,
    input wire logic sleep_in,
    input wire rst_seq_pkg::config_bits_t config_in,
    input wire rst_seq_pkg::reset_events_t events_in,
    input wire logic [`ADDR_W-1:0] reg_addr_in,
    input wire logic [`DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [`DATA_W-1:0] reg_rdata_out,
    output logic internal_reset_out,
    output logic brownout_reset_out,
    output logic brownout_detect_enable_out,
    output logic brownout_level_low_out,
    output logic band_gap_force_on_out,
    output logic wake_hold_out,
    output logic power_up_timer_running_out
);

    localparam logic [`POWER_UP_TIMER_CNT_W-1:0] POWER_UP_TIMER_LAST = POWER_UP_TIMER_CYCLES - `POWER_UP_TIMER_CNT_W'(1);
    localparam logic [`FILT_CNT_W-1:0] BOR_FILT = `FILT_CNT_W'(`BOR_FILTER_CYCLES);
    localparam logic [`FILT_CNT_W-1:0] MASTER_CLEAR_PIN_FILT = `FILT_CNT_W'(`MASTER_CLEAR_PIN_FILTER_CYCLES);
    localparam logic [`FILT_CNT_W-1:0] FILT_ONE = `FILT_CNT_W'(1);
    // Power-on detector assumed low, brown-out inputs assumed clear and pin assumed idle high in reset, so no false release follows it.
    localparam logic [`SYNC_W-1:0] SYNC_RST = `SYNC_RESET;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [`SYNC_W-1:0] raw_in;
    logic [`SYNC_W-1:0] sync1_q;
    logic [`SYNC_W-1:0] sync2_q;

    assign raw_in = {master_clear_pin_n_in, brownout_circuit_ready_in,
        low_power_brownout_vdd_low_in, bor_vdd_below_in, por_vdd_low_in};

    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge clk_sys_in or posedge reset_in)
            begin
                if (reset_in)
                begin
                    sync1_q[gi] <= SYNC_RST[gi];
                    sync2_q[gi] <= SYNC_RST[gi];
                end
                else
                begin
                    sync1_q[gi] <= raw_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    logic por_s;
    logic below_s;
    logic low_power_brownout_s;
    logic ready_s;
    logic pin_n_s;

    assign por_s = sync2_q[0];
    assign below_s = sync2_q[1];
    assign low_power_brownout_s = sync2_q[2];
    assign ready_s = sync2_q[3];
    assign pin_n_s = sync2_q[4];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    rst_seq_pkg::seq_state_t state_q, state_d;
    logic [`POWER_UP_TIMER_CNT_W-1:0] power_up_timer_cnt_q, power_up_timer_cnt_d;
    logic [`FILT_CNT_W-1:0] bor_cnt_q, bor_cnt_d;
    logic [`FILT_CNT_W-1:0] master_clear_pin_cnt_q, master_clear_pin_cnt_d;
    logic bor_trip_q, bor_trip_d;
    logic master_clear_pin_hold_q, master_clear_pin_hold_d;
    logic brown_q, brown_d;
    logic sw_en_q, sw_en_d;
    logic fast_q, fast_d;
    logic [`DATA_W-1:0] rdata_q, rdata_d;
    logic irst_q, irst_d;
    logic det_en_q, det_en_d;
    logic level_q, level_d;
    logic gap_q, gap_d;
    logic wake_q, wake_d;
    logic bor_en;
    logic master_clear_pin_en;
    logic low_power_brownout_trip;
    logic evt_any;
    logic ready_ok;
    logic [1:0] mode;

    assign mode = config_in.brownout_mode_select;

    always_comb
    begin
        unique case (mode)
            `MODE_ALWAYS: bor_en = 1'h1;
            `MODE_AWAKE: bor_en = !sleep_in;
            `MODE_SOFTWARE: bor_en = sw_en_q;
            `MODE_OFF: bor_en = 1'h0;
        endcase
    end

    always_comb
    begin
        // Detection is armed only once the analog circuit reports ready.
        if (bor_en && ready_s && below_s)
        begin
            bor_cnt_d = (bor_cnt_q == BOR_FILT) ? bor_cnt_q : bor_cnt_q + FILT_ONE;
            bor_trip_d = bor_trip_q || (bor_cnt_q == BOR_FILT);
        end
        else
        begin
            bor_cnt_d = '0;
            bor_trip_d = 1'h0;
        end
        low_power_brownout_trip = low_power_brownout_s && !config_in.low_power_brownout_enable_n;
        brown_d = bor_trip_q || low_power_brownout_trip;
        master_clear_pin_en = config_in.low_voltage_program_enable
            || config_in.master_clear_pin_enable;
        if (master_clear_pin_en && !pin_n_s)
        begin
            master_clear_pin_cnt_d = (master_clear_pin_cnt_q == MASTER_CLEAR_PIN_FILT) ? master_clear_pin_cnt_q : master_clear_pin_cnt_q + FILT_ONE;
            master_clear_pin_hold_d = master_clear_pin_hold_q || (master_clear_pin_cnt_q == MASTER_CLEAR_PIN_FILT);
        end
        else
        begin
            master_clear_pin_cnt_d = '0;
            master_clear_pin_hold_d = 1'h0;
        end
    end

    always_comb
    begin
        state_d = state_q;
        power_up_timer_cnt_d = power_up_timer_cnt_q;
        // Modes 11 and 10 wait for the ready flag; 01 and 00 do not.
        ready_ok = !mode[1] || ready_s;
        unique case (state_q)
            rst_seq_pkg::ST_POWER_HOLD:
            begin
                power_up_timer_cnt_d = '0;
                if (!por_s && !brown_q)
                begin
                    if (!config_in.power_up_timer_enable_n)
                        state_d = rst_seq_pkg::ST_TIMER;
                    else
                        state_d = rst_seq_pkg::ST_WAIT;
                end
            end
            rst_seq_pkg::ST_TIMER:
            begin
                power_up_timer_cnt_d = power_up_timer_cnt_q + `POWER_UP_TIMER_CNT_W'(1);
                if (power_up_timer_cnt_q == POWER_UP_TIMER_LAST)
                    state_d = rst_seq_pkg::ST_WAIT;
            end
            rst_seq_pkg::ST_WAIT:
            begin
                if (osc_startup_done_in && ready_ok)
                    state_d = rst_seq_pkg::ST_RUN;
            end
            rst_seq_pkg::ST_RUN:
            begin
                state_d = rst_seq_pkg::ST_RUN;
            end
        endcase
        // Leaving programming mode behaves like a fresh power-on.
        if (por_s || brown_q || events_in.program_mode_exit)
            state_d = rst_seq_pkg::ST_POWER_HOLD;
    end

    always_comb
    begin
        evt_any = events_in.watchdog_timer || events_in.reset_instruction
            || events_in.stack_overflow || events_in.stack_underflow
            || events_in.program_mode_exit;
        // The pin gates only the output, so the timers expire underneath it.
        irst_d = por_s || brown_q || (state_d != rst_seq_pkg::ST_RUN)
            || master_clear_pin_hold_d || evt_any;
        det_en_d = bor_en;
        level_d = config_in.brownout_level_select;
        gap_d = fast_q && (mode == `MODE_AWAKE || mode == `MODE_SOFTWARE);
        wake_d = (mode == `MODE_AWAKE) && !ready_s;
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_comb
    begin
        sw_en_d = sw_en_q;
        fast_d = fast_q;
        rdata_d = '0;
        if (reg_wr_in && reg_addr_in == `BROWNOUT_CONTROL_ADDR)
        begin
            sw_en_d = reg_wdata_in[`BROWNOUT_CONTROL_SW_EN_BIT];
            fast_d = reg_wdata_in[`BROWNOUT_CONTROL_FAST_BIT];
        end
        if (reg_rd_in && reg_addr_in == `BROWNOUT_CONTROL_ADDR)
        begin
            // Unlisted bits stay zero from the default above.
            rdata_d[`BROWNOUT_CONTROL_SW_EN_BIT] = sw_en_q;
            rdata_d[`BROWNOUT_CONTROL_FAST_BIT] = fast_q;
            rdata_d[`BROWNOUT_CONTROL_RDY_BIT] = ready_s;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            state_q <= rst_seq_pkg::ST_POWER_HOLD;
            power_up_timer_cnt_q <= '0;
            bor_cnt_q <= '0;
            master_clear_pin_cnt_q <= '0;
            bor_trip_q <= 1'h0;
            master_clear_pin_hold_q <= 1'h0;
            brown_q <= 1'h0;
            sw_en_q <= `BROWNOUT_CONTROL_SW_EN_RESET;
            fast_q <= `BROWNOUT_CONTROL_FAST_RESET;
            rdata_q <= '0;
            irst_q <= 1'h1;
            det_en_q <= 1'h0;
            level_q <= 1'h0;
            gap_q <= 1'h0;
            wake_q <= 1'h0;
        end
        else
        begin
            state_q <= state_d;
            power_up_timer_cnt_q <= power_up_timer_cnt_d;
            bor_cnt_q <= bor_cnt_d;
            master_clear_pin_cnt_q <= master_clear_pin_cnt_d;
            bor_trip_q <= bor_trip_d;
            master_clear_pin_hold_q <= master_clear_pin_hold_d;
            brown_q <= brown_d;
            sw_en_q <= sw_en_d;
            fast_q <= fast_d;
            rdata_q <= rdata_d;
            irst_q <= irst_d;
            det_en_q <= det_en_d;
            level_q <= level_d;
            gap_q <= gap_d;
            wake_q <= wake_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign internal_reset_out = irst_q;
    assign brownout_reset_out = brown_q;
    assign brownout_detect_enable_out = det_en_q;
    assign brownout_level_low_out = level_q;
    assign band_gap_force_on_out = gap_q;
    assign wake_hold_out = wake_q;
    assign power_up_timer_running_out = (state_q == rst_seq_pkg::ST_TIMER);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    sequence s_pin_low_filtered;
        (master_clear_pin_en && !pin_n_s) [*8];
    endsequence

    sequence s_supply_low;
        por_s ##1 por_s;
    endsequence

    property p_por_hold;
        s_supply_low |=> internal_reset_out;
    endproperty
    a_por_hold: assert property (p_por_hold) else $error("reset released under low supply");

    property p_timer_hold;
        (state_q == rst_seq_pkg::ST_TIMER) |=> internal_reset_out;
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("reset released during timer");

    property p_timer_bypass;
        (state_q == rst_seq_pkg::ST_POWER_HOLD) && config_in.power_up_timer_enable_n
            |=> state_q != rst_seq_pkg::ST_TIMER;
    endproperty
    a_timer_bypass: assert property (p_timer_bypass) else $error("timer ran while bypassed");

    property p_timer_start;
        $rose(state_q == rst_seq_pkg::ST_TIMER) |-> $past(!por_s && !brown_q);
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer started too early");

    property p_filter;
        $rose(bor_trip_q) |-> $past(bor_cnt_q) == BOR_FILT;
    endproperty
    a_filter: assert property (p_filter) else $error("brown-out trip before filter time");

    property p_mode_off;
        (mode == `MODE_OFF) ##1 (mode == `MODE_OFF) |=> !brownout_detect_enable_out && !bor_trip_q;
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("detection active in off mode");

    property p_fast_start;
        mode[1] == mode[0] |=> !band_gap_force_on_out;
    endproperty
    a_fast_start: assert property (p_fast_start) else $error("band gap forced in modes 11/00");

    property p_reserved;
        reg_rd_in |=> reg_rdata_out[5:1] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

    property p_low_power_brownout;
        low_power_brownout_s && !config_in.low_power_brownout_enable_n |=> brownout_reset_out ##1 internal_reset_out;
    endproperty
    a_low_power_brownout: assert property (p_low_power_brownout) else $error("low-power request lost");

    property p_pin_hold;
        s_pin_low_filtered ##0 (master_clear_pin_cnt_q == MASTER_CLEAR_PIN_FILT) |=> internal_reset_out;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin low did not hold reset");

endmodule // reset_source_sequencer
`default_nettype wire

// ### test/supply_pin_model.sv
// Behavioural supply detectors and master clear pin for the sequencer bench.
`timescale 1ns/1ps
`default_nettype none
module supply_pin_model (
    input wire logic clk_sys_in,
    input wire logic [1:0] vdd_level_in,
    input wire logic lp_low_in,
    input wire logic pin_pull_low_in,
    output logic por_vdd_low_out,
    output logic bor_vdd_below_out,
    output logic low_power_brownout_vdd_low_out,
    output logic ready_out,
    output logic master_clear_pin_n_out
);
    // The ready flag rises a few cycles after the supply leaves the power-on region.
    logic [2:0] ready_cnt_q = 3'h0;
    always_ff @(posedge clk_sys_in)
    begin
        if (vdd_level_in == 2'h0)
        begin
            ready_cnt_q <= 3'h0;
        end
        else if (ready_cnt_q != 3'h7)
        begin
            ready_cnt_q <= ready_cnt_q + 3'h1;
        end
    end
    assign por_vdd_low_out = (vdd_level_in == 2'h0);
    assign bor_vdd_below_out = (vdd_level_in != 2'h2);
    assign low_power_brownout_vdd_low_out = lp_low_in;
    assign ready_out = (ready_cnt_q == 3'h7);
    // The weak pull-up holds the pin high whenever nobody pulls it low.
    assign master_clear_pin_n_out = !pin_pull_low_in;
endmodule // supply_pin_model
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for the reset source sequencer.
`include "rst_seq_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int TMR = 64;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic [1:0] vdd = 2'h0;
    logic lp_low = 1'b0;
    logic pin_low = 1'b0;
    logic sleep = 1'b0;
    rst_seq_pkg::config_bits_t cfg = '{1'b0, 2'h3, 1'b0, 1'b1, 1'b1, 1'b0};
    rst_seq_pkg::reset_events_t ev = '0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata_out;
    logic por_low, bor_below, lp_out, ready, pin_n;
    logic internal_reset_out, brownout_reset_out, det, lvl, bg, power_up_timer_running_out;
    logic [7:0] d;
    logic si, sb, t, wake;
    logic osc_done = 1'b1;
    int n;
    int error_cnt = 0;
    int check_count = 0;
    logic [6:0] rows [6] = '{7'h6E, 7'h5B, 7'h54, 7'h3F, 7'h20, 7'h18};
    logic [2:0] pcfg [4] = '{3'h4, 3'h5, 3'h0, 3'h3};
    int plen [4] = '{10, 40, 40, 40};

    supply_pin_model supply_pin_model_inst (.clk_sys_in(clk_sys_in), .vdd_level_in(vdd),
        .lp_low_in(lp_low), .pin_pull_low_in(pin_low), .por_vdd_low_out(por_low),
        .bor_vdd_below_out(bor_below), .low_power_brownout_vdd_low_out(lp_out), .ready_out(ready),
        .master_clear_pin_n_out(pin_n));

    reset_source_sequencer #(.POWER_UP_TIMER_CYCLES(`POWER_UP_TIMER_CNT_W'(TMR))) reset_source_sequencer_inst (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in), .por_vdd_low_in(por_low),
        .bor_vdd_below_in(bor_below), .low_power_brownout_vdd_low_in(lp_out),
        .brownout_circuit_ready_in(ready), .master_clear_pin_n_in(pin_n),
        .osc_startup_done_in(osc_done), .sleep_in(sleep), .config_in(cfg), .events_in(ev),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata_out),
        .internal_reset_out(internal_reset_out), .brownout_reset_out(brownout_reset_out),
        .brownout_detect_enable_out(det), .brownout_level_low_out(lvl),
        .band_gap_force_on_out(bg), .wake_hold_out(wake),
        .power_up_timer_running_out(power_up_timer_running_out));

    initial
    begin
        forever #5 clk_sys_in = !clk_sys_in;
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask

    task automatic watch(input int cycles);
        repeat (cycles)
        begin
            @(posedge clk_sys_in);
            #1;
            si |= internal_reset_out;
            sb |= brownout_reset_out;
        end
    endtask

    task automatic wait_run;
        n = 0;
        t = 1'b0;
        while (internal_reset_out !== 1'b0 && n < 3000)
        begin
            @(posedge clk_sys_in);
            #1;
            t |= power_up_timer_running_out;
            n++;
        end
        chk("run reached", 8'(internal_reset_out), 8'h00);
    endtask

    task automatic final_report;
        $display("Checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial
    begin
        #500us;
        error_cnt++;
        final_report();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        rd(`BROWNOUT_CONTROL_ADDR);
        chk("control reset", d, 8'h80);
        si = 1'b0;
        watch(20);
        chk("held by supply", 8'(si), 8'h01);
        vdd <= 2'h2;
        wait_run();
        chk("timer length", 8'(n >= TMR), 8'h01);
        chk("timer seen", 8'(t), 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            cfg.brownout_mode_select <= rows[i][6:5];
            sleep <= rows[i][2];
            wr(`BROWNOUT_CONTROL_ADDR, {rows[i][4:3], 6'h00});
            repeat (4) @(posedge clk_sys_in);
            #1;
            chk("detect", 8'(det), 8'(rows[i][1]));
            chk("band gap", 8'(bg), 8'(rows[i][0]));
            rd(`BROWNOUT_CONTROL_ADDR);
            chk("control", d, {rows[i][4:3], 6'h01});
        end
        cfg.brownout_mode_select <= 2'h3;
        sleep <= 1'b0;
        wr(`BROWNOUT_CONTROL_ADDR, 8'h80);
        wr(4'h5, 8'h00);
        rd(4'h5);
        chk("unmapped", d, 8'h00);
        rd(`BROWNOUT_CONTROL_ADDR);
        chk("control kept", d, 8'h81);
        cfg.brownout_level_select <= 1'b1;
        watch(4);
        chk("level", 8'(lvl), 8'h01);
        si = 1'b0;
        sb = 1'b0;
        vdd <= 2'h1;
        watch(50);
        vdd <= 2'h2;
        watch(10);
        chk("short dip", 8'(sb), 8'h00);
        vdd <= 2'h1;
        watch(150);
        vdd <= 2'h2;
        chk("long dip", 8'({sb, si}), 8'h03);
        wait_run();
        sb = 1'b0;
        lp_low <= 1'b1;
        watch(150);
        lp_low <= 1'b0;
        chk("low power off", 8'(sb), 8'h00);
        cfg.low_power_brownout_enable_n <= 1'b0;
        lp_low <= 1'b1;
        watch(150);
        lp_low <= 1'b0;
        chk("low power on", 8'(sb), 8'h01);
        wait_run();
        for (int i = 0; i < 4; i++)
        begin
            cfg.master_clear_pin_enable <= pcfg[i][2];
            cfg.low_voltage_program_enable <= pcfg[i][1];
            watch(2);
            si = 1'b0;
            pin_low <= 1'b1;
            watch(plen[i]);
            pin_low <= 1'b0;
            watch(6);
            chk("pin", 8'(si), 8'(pcfg[i][0]));
            wait_run();
        end
        cfg.master_clear_pin_enable <= 1'b1;
        cfg.low_voltage_program_enable <= 1'b0;
        cfg.brownout_mode_select <= 2'h2;
        vdd <= 2'h0;
        pin_low <= 1'b1;
        watch(10);
        chk("wake hold", 8'(wake), 8'h01);
        vdd <= 2'h2;
        watch(200);
        chk("wake free", 8'(wake), 8'h00);
        pin_low <= 1'b0;
        wait_run();
        chk("pin release", 8'(n < 30), 8'h01);
        osc_done <= 1'b0;
        vdd <= 2'h0;
        watch(10);
        vdd <= 2'h2;
        watch(200);
        chk("osc wait", 8'(internal_reset_out), 8'h01);
        osc_done <= 1'b1;
        wait_run();
        chk("osc release", 8'(n < 30), 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            si = 1'b0;
            ev <= 5'h01 << i;
            watch(1);
            ev <= 5'h00;
            watch(4);
            chk("event", 8'(si), 8'h01);
            wait_run();
        end
        final_report();
    end
endmodule // tb
`default_nettype wire
